// file: hdl/pcp_pkg.sv
`default_nettype none
package pcp_pkg;
    // number of output counters (input divider and feedback counter not included)
    localparam int NUM_OUT = 5;
    // phase taps per output counter: each step is one core clock of delay
    localparam int TAPS = 8;
    localparam int TAP_W = 3;
    // setting word per counter: bit 8 is the bypass bit, bits 7..0 divide
    localparam int SET_W = 9;
    localparam int BYPASS_BIT = 8;
    localparam int DIV_W = 8;
    // counter select codes
    localparam logic [2:0] SEL_ALL = 3'h0;
    localparam logic [2:0] SEL_FB = 3'h1;
    localparam logic [2:0] SEL_OUT0 = 3'h2;
    // reset values
    localparam logic [SET_W-1:0] SET_RESET = 9'h100;
    localparam logic [TAP_W-1:0] TAP_RESET = 3'h0;
    // register map on the plain port
    localparam logic [3:0] ADDR_IN_SET = 4'h0;
    localparam logic [3:0] ADDR_OUT_SET0 = 4'h1;
    localparam logic [3:0] ADDR_FB_SET = 4'h6;
    localparam logic [3:0] ADDR_TAPS = 4'h7;
    localparam logic [3:0] ADDR_STEPS = 4'h8;
    localparam logic [3:0] ADDR_TAP_LAST = 4'h9;
endpackage
`default_nettype wire

// file: hdl/pcp_divider.sv
`default_nettype none
// one post-scale counter: divide by setting, or by one when bypassed
module pcp_divider
    import pcp_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic [pcp_pkg::SET_W-1:0] setting,
    output logic divOut
);
    logic [DIV_W-1:0] cnt_reg, cnt_next;
    logic out_reg, out_next;
    logic bypass;
    logic [DIV_W-1:0] div;

    // bypass ignores the divide bits entirely
    always_comb begin
        bypass = setting[BYPASS_BIT];
        div = setting[DIV_W-1:0];
        cnt_next = cnt_reg;
        out_next = out_reg;
        if (bypass || div <= 8'h01) begin
            // divide by one: output toggles every clock, a square at clock rate / 2
            cnt_next = '0;
            out_next = ~out_reg;
        end else if (cnt_reg >= div - 8'h01) begin
            cnt_next = '0;
            out_next = 1'b1;
        end else begin
            cnt_next = cnt_reg + 8'h01;
            out_next = (cnt_reg + 8'h01) < (div >> 1);
        end
    end

    // never gated: outputs run during phase changes
    always_ff @(posedge clock) begin
        if (srst) begin
            cnt_reg <= '0;
            out_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            out_reg <= out_next;
        end
    end

    assign divOut = out_reg;
endmodule
`default_nettype wire

// file: hdl/pcp_pll_ctrl.sv
`default_nettype none
module pcp_pll_ctrl
    import pcp_pkg::*;
#(
    parameter int NOUT = pcp_pkg::NUM_OUT
) (
    // core clock and its synchronous reset
    input wire logic clock,
    input wire logic srst,
    // reconfiguration clock of the step request
    input wire logic scanClock,
    // register port, core clock
    input wire logic [3:0] addr,
    input wire logic [15:0] wrData,
    input wire logic wrStb,
    input wire logic rdStb,
    output logic [15:0] rdData,
    // phase step request from the fabric, scan clock
    input wire logic [2:0] phaseCounterSelect,
    input wire logic phaseUpDown,
    input wire logic phaseStep,
    // divided clocks, core clock
    output logic inDivOut,
    output logic [NOUT-1:0] outputCounters
);
    import pcp_pkg::*;

    // scan clock domain: the step request arrives here and its select
    // and direction are caught on a fresh rising edge of the request
    // nothing in this half ever waits on the core clock; the only thing
    // that leaves it is a toggle plus two words held still behind it
    // link reset: srst brought over to the scan clock
    // srst must stay high for four scan edges so that this copy rises
    // while the core side is still held, else a toggle reset could leak
    logic lrst1_reg; // first stage, may go metastable
    logic lrst2_reg; // settled reset for the scan side
    // step request synchroniser and edge memory
    logic step1_reg; // first stage, read by the second stage only
    logic step2_reg; // settled request level
    logic step3_reg; // request level one scan edge earlier
    // captured select and direction
    logic [2:0] sel_reg; // counter select held for the core side
    logic [2:0] sel_next;
    logic dir_reg; // direction held for the core side
    logic dir_next;
    // event toggle toward the core domain
    // a toggle rather than a pulse, so a slow core clock cannot miss it
    logic tog_reg;
    logic tog_next;
    // one scan cycle wide when the settled request goes high
    logic stepRise;

    // the request is from fabric logic on another clock, so it is synced
    // select and direction are not synced: they must be still around the
    // capturing edge, which the fabric promises
    // none of these stages has a reset: they follow the pins within
    // three scan edges, and a request that is already high when reset
    // ends is not taken as a fresh edge
    always_ff @(posedge scanClock) begin
        lrst1_reg <= srst;
        lrst2_reg <= lrst1_reg;
        step1_reg <= phaseStep;
        step2_reg <= step1_reg;
        step3_reg <= step2_reg;
    end

    // capture select and direction on a fresh request edge only
    // a request held high for many scan edges still counts once
    always_comb begin
        // default: hold what was caught last time
        stepRise = step2_reg & ~step3_reg;
        sel_next = sel_reg;
        dir_next = dir_reg;
        tog_next = tog_reg;
        if (stepRise) begin
            sel_next = phaseCounterSelect;
            dir_next = phaseUpDown;
            // flip the toggle on the same edge as the words it guards
            tog_next = ~tog_reg;
        end
    end

    // select and direction stay still until the toggle has been seen
    // the next request may not come before the core side has used them,
    // which the minimum low time of the request guarantees
    always_ff @(posedge scanClock) begin
        if (lrst2_reg) begin
            // reset select points at all outputs, direction down
            sel_reg <= SEL_ALL;
            dir_reg <= 1'b0;
            tog_reg <= 1'b0;
        end else begin
            sel_reg <= sel_next;
            dir_reg <= dir_next;
            tog_reg <= tog_next;
        end
    end

    // core clock domain: register port, settings, taps and outputs
    // toggle synchroniser; sel and dir are stable when toggle lands
    logic tg1_reg; // first stage, read by the second stage only
    logic tg2_reg; // settled toggle
    logic tg3_reg; // settled toggle one clock earlier
    logic [2:0] selC_reg; // select copy, only used behind the toggle
    logic dirC_reg; // direction copy, only used behind the toggle
    // the copies of select and direction may be caught mid-change, but
    // they are read only once the toggle has passed two stages, by which
    // time the scan side has held them still for at least a clock
    always_ff @(posedge clock) begin
        tg1_reg <= tog_reg;
        tg2_reg <= tg1_reg;
        tg3_reg <= tg2_reg;
        selC_reg <= sel_reg;
        dirC_reg <= dir_reg;
    end
    // one core cycle wide for each request taken on the scan side
    logic stepEvt;
    assign stepEvt = tg2_reg ^ tg3_reg;

    // counter settings: input divider, outputs, feedback
    // bit 8 bypasses, bits 7..0 give the divide factor
    logic [SET_W-1:0] inSet_reg, inSet_next;
    logic [SET_W-1:0] outSet_reg [NOUT], outSet_next [NOUT];
    logic [SET_W-1:0] fbSet_reg, fbSet_next;
    // phase tap per output counter and feedback counter
    // all taps start at zero, so every output starts with no delay
    logic [TAP_W-1:0] tap_reg [NOUT], tap_next [NOUT];
    logic [TAP_W-1:0] fbTap_reg, fbTap_next;
    // count of steps taken, visible to software
    // it wraps at 16 bits; software compares before and after a burst
    logic [15:0] steps_reg;
    logic [15:0] steps_next;
    // read data register, zero in every cycle not after a read strobe
    logic [15:0] rd_reg;
    logic [15:0] rd_next;

    // one step moves a tap by one of eight positions, wrapping
    // wrapping from the last tap to the first takes the delay from seven clocks
    // back to none, so only at a period of two, four or eight clocks does a long run of steps in one
    // direction keep moving the phase evenly
    function automatic logic [TAP_W-1:0] stepTap(
        input logic [TAP_W-1:0] t, input logic up);
        stepTap = up ? t + 3'h1 : t - 3'h1;
    endfunction

    // register writes and phase steps
    // a write and a step in the same cycle touch different state, so
    // neither has to win over the other
    always_comb begin
        // default: every setting and tap holds
        inSet_next = inSet_reg;
        fbSet_next = fbSet_reg;
        fbTap_next = fbTap_reg;
        steps_next = steps_reg;
        for (int i = 0; i < NOUT; i++) begin
            outSet_next[i] = outSet_reg[i];
            tap_next[i] = tap_reg[i];
        end
        // writes to unmapped offsets fall through and change nothing
        if (wrStb) begin
            // only the nine setting bits are kept, upper data bits drop
            if (addr == ADDR_IN_SET)
                inSet_next = wrData[SET_W-1:0];
            if (addr == ADDR_FB_SET)
                fbSet_next = wrData[SET_W-1:0];
            for (int i = 0; i < NOUT; i++)
                if (addr == ADDR_OUT_SET0 + 4'(i))
                    outSet_next[i] = wrData[SET_W-1:0];
        end
        // tap moves directly, no serial scan traffic needed
        if (stepEvt) begin
            // every taken request is counted, even one whose select
            // code matches no counter
            steps_next = steps_reg + 16'h0001;
            // the feedback counter only keeps its tap here, it has no
            // clock output of its own in this block
            if (selC_reg == SEL_FB)
                fbTap_next = stepTap(fbTap_reg, dirC_reg);
            for (int i = 0; i < NOUT; i++)
                if (selC_reg == SEL_ALL || selC_reg == SEL_OUT0 + 3'(i))
                    tap_next[i] = stepTap(tap_reg[i], dirC_reg);
        end
    end

    // read mux, data stand the cycle after the strobe
    // reads have no side effects, so software may poll freely
    always_comb begin
        // default: read data return to zero after their one cycle
        rd_next = 16'h0000;
        if (rdStb) begin
            // fixed offsets first, the output setting block after
            case (addr)
                ADDR_IN_SET: rd_next = 16'(inSet_reg);
                ADDR_FB_SET: rd_next = 16'(fbSet_reg);
                ADDR_TAPS: rd_next = {1'b0, fbTap_reg, tap_reg[3],
                    tap_reg[2], tap_reg[1], tap_reg[0]};
                ADDR_STEPS: rd_next = steps_reg;
                default: rd_next = 16'h0000;
            endcase
            for (int i = 0; i < NOUT; i++)
                if (addr == ADDR_OUT_SET0 + 4'(i))
                    rd_next = 16'(outSet_reg[i]);
            // the last output's tap does not fit the packed tap word
            if (addr == ADDR_TAP_LAST)
                rd_next = 16'(tap_reg[NOUT-1]);
        end
    end

    // settings, taps, step count and read data only register here
    // reset leaves every counter bypassed with its tap at zero
    always_ff @(posedge clock) begin
        if (srst) begin
            inSet_reg <= SET_RESET;
            fbSet_reg <= SET_RESET;
            fbTap_reg <= TAP_RESET;
            steps_reg <= 16'h0000;
            rd_reg <= 16'h0000;
            for (int i = 0; i < NOUT; i++) begin
                outSet_reg[i] <= SET_RESET;
                tap_reg[i] <= TAP_RESET;
            end
        end else begin
            inSet_reg <= inSet_next;
            fbSet_reg <= fbSet_next;
            fbTap_reg <= fbTap_next;
            steps_reg <= steps_next;
            rd_reg <= rd_next;
            for (int i = 0; i < NOUT; i++) begin
                outSet_reg[i] <= outSet_next[i];
                tap_reg[i] <= tap_next[i];
            end
        end
    end
    assign rdData = rd_reg;

    // phase taps: an eight-step history of each output counter
    // one step is one core clock of delay, so it is exactly an eighth of
    // a period only when the counter divides by eight; the trade keeps
    // the outputs free of any gating
    logic inRaw; // input divider output before its output register
    logic [NOUT-1:0] outRaw; // output counters before the tap line
    logic [NOUT-1:0] outQ_reg; // tapped outputs, straight to the pins
    logic [NOUT-1:0] outQ_next;
    logic [TAPS-1:0] hist_reg [NOUT]; // newest sample in bit 0
    logic inQ_reg; // input divider output register

    // input divider: bypassable like the outputs, but it has no tap line
    pcp_divider u_in (
        .clock(clock),
        .srst(srst),
        .setting(inSet_reg),
        .divOut(inRaw)
    );

    // each output counter is a divider feeding a tap delay line
    // the history is read at the tap, so a changed tap takes effect on
    // the very next clock without any settling time
    genvar g;
    generate
        for (g = 0; g < NOUT; g++) begin : gOut
            pcp_divider u_div (
                .clock(clock),
                .srst(srst),
                .setting(outSet_reg[g]),
                .divOut(outRaw[g])
            );
            // shift the divider output into the history every clock
            always_ff @(posedge clock) begin
                if (srst)
                    hist_reg[g] <= '0;
                else
                    hist_reg[g] <= {hist_reg[g][TAPS-2:0], outRaw[g]};
            end
            // tap select only delays, never gates the clock
            always_comb outQ_next[g] = hist_reg[g][tap_reg[g]];
        end
    endgenerate

    // output registers: every pin of the block comes from a flip-flop
    // a tap change moves the edge by one clock, or seven where the tap wraps, so the outputs
    // never stop toggling while the phase is moving
    always_ff @(posedge clock) begin
        if (srst) begin
            outQ_reg <= '0;
            inQ_reg <= 1'b0;
        end else begin
            outQ_reg <= outQ_next;
            inQ_reg <= inRaw;
        end
    end
    assign outputCounters = outQ_reg;
    assign inDivOut = inQ_reg;
endmodule
`default_nettype wire

// file: testbench/pcp_monitor.sv
`default_nettype none
module pcp_monitor
    import pcp_pkg::*;
#(
    parameter int NOUT = pcp_pkg::NUM_OUT
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic [3:0] addr,
    input wire logic [15:0] wrData,
    input wire logic wrStb,
    input wire logic rdStb,
    input wire logic [15:0] rdData,
    input wire logic phaseStep,
    input wire logic [NOUT-1:0] outputCounters
);
    timeunit 1ns;
    timeprecision 1ps;
    // shadow of output counter 1 setting, taken from the write port
    logic [8:0] shReg;
    logic [8:0] shNext;
    logic divides;
    always_comb begin
        shNext = shReg;
        if (wrStb && addr == 4'h2)
            shNext = wrData[8:0];
    end
    always_ff @(posedge clock) begin
        shReg <= srst ? SET_RESET : shNext;
    end
    // toggling is checked only for a real divide; divide by one, which toggles every clock, is left out
    assign divides = !shReg[8] && shReg[7:0] > 8'h01;
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    rd_idle_zero_a: assert property (!$past(rdStb) |-> rdData == 16'h0)
        else $error("read data outside its slot");
    unmapped_zero_a: assert property (rdStb && addr > 4'h9 |=> !rdData)
        else $error("unmapped read not zero");
    set_readback_a: assert property (rdStb && addr == 4'h2 |=>
        rdData == {7'h0, $past(shReg)}) else $error("setting readback");
    set_width_a: assert property (rdStb && addr <= ADDR_FB_SET |=>
        rdData[15:9] == 7'h0) else $error("setting upper bits");
    tap_top_a: assert property (rdStb && addr == ADDR_TAPS |=>
        rdData[15] == 1'b0) else $error("tap word top bit");
    tap_last_a: assert property (rdStb && addr == 4'h9 |=>
        rdData[15:3] == 13'h0) else $error("tap of output 4 width");
    out_runs_a: assert property (divides |-> ##[1:600]
        $changed(outputCounters[1])) else $error("output stopped");
    step_runs_a: assert property ($rose(phaseStep) && divides |->
        ##[1:600] $changed(outputCounters[1])) else $error("stopped in step");
    cover property ($rose(phaseStep));
    cover property (rdStb && addr == ADDR_TAPS);
    cover property (wrStb && addr == ADDR_IN_SET);
endmodule
bind pcp_pll_ctrl pcp_monitor #(.NOUT(NOUT)) mon (.clock, .srst, .addr,
    .wrData, .wrStb, .rdStb, .rdData, .phaseStep, .outputCounters);
`default_nettype wire

// file: testbench/pcp_fabric.sv
`default_nettype none
// fabric logic that asks for phase steps on the reconfiguration clock
module pcp_fabric (
    input wire logic scanClock,
    output logic [2:0] phaseCounterSelect,
    output logic phaseUpDown,
    output logic phaseStep
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        phaseCounterSelect = 3'h0;
        phaseUpDown = 1'b0;
        phaseStep = 1'b0;
    end
    // select and direction settle first and stay until capture is over
    task automatic step(input logic [2:0] s, input logic d, input int hold);
        @(posedge scanClock);
        phaseCounterSelect <= s;
        phaseUpDown <= d;
        @(posedge scanClock);
        phaseStep <= 1'b1;
        repeat (hold) @(posedge scanClock);
        phaseStep <= 1'b0;
        repeat (3) @(posedge scanClock);
        // stale values are scrambled so nobody can lean on them
        phaseCounterSelect <= ~s;
        phaseUpDown <= ~d;
    endtask
endmodule
`default_nettype wire

// file: testbench/tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pcp_pkg::*;
    // a bypassed counter toggles every clock: two clocks rise to rise
    localparam int BYP_PER = 2;
    logic clock, srst, scanClock, wrStb, rdStb, inDivOut, d;
    logic phaseUpDown, phaseStep;
    logic [3:0] addr;
    logic [15:0] wrData, rdData;
    logic [2:0] phaseCounterSelect, sl;
    logic [4:0] outputCounters;
    logic [31:0] lfsr;
    logic [8:0] s;
    logic [2:0] tp [0:5];
    logic [8:0] cor [3] = '{9'h1A5, 9'h002, 9'h0FF};
    int num_errors, check_count, i, k, p, p1;
    pcp_pll_ctrl dut (.clock, .srst, .scanClock, .addr, .wrData, .wrStb,
        .rdStb, .rdData, .phaseCounterSelect, .phaseUpDown, .phaseStep,
        .inDivOut, .outputCounters);
    pcp_fabric fab (.scanClock, .phaseCounterSelect, .phaseUpDown,
        .phaseStep);
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // link clock, free running and out of phase with the core clock
    initial begin
        scanClock = 1'b0;
        #17;
        forever #62.5 scanClock = ~scanClock;
    end
    function automatic logic [31:0] nxt(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [2:0] mv(input logic [2:0] t, input logic up);
        return up ? t + 3'h1 : t - 3'h1;
    endfunction
    function automatic int per(input logic [8:0] v, input int one);
        return (v[8] || v[7:0] < 8'h02) ? one : int'(v[7:0]);
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge clock);
        addr <= a;
        wrData <= v;
        wrStb <= 1'b1;
        @(posedge clock);
        wrStb <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clock);
        addr <= a;
        rdStb <= 1'b1;
        @(posedge clock);
        rdStb <= 1'b0;
        #1 chk(rdData, exp);
    endtask
    // rise to rise of the input divider; the first rise after a setting
    // change may be a left-over of the old count, so it is skipped
    task automatic meas(output int r);
        int t0, n, rises;
        logic prv;
        t0 = -1;
        r = 0;
        rises = 0;
        prv = 1'bx;
        for (n = 1; n < 1000 && r == 0; n++) begin
            @(posedge clock);
            #1;
            if (inDivOut === 1'b1 && prv === 1'b0) begin
                rises++;
                if (rises == 2)
                    t0 = n;
                else if (rises == 3)
                    r = n - t0;
            end
            prv = inDivOut;
        end
        if (r == 0) begin
            num_errors++;
            $display("[FAIL] %0t input divider output sits", $time);
            results();
        end
    endtask
    task automatic results();
        if (num_errors == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        {srst, wrStb, rdStb, addr, wrData} = {3'b100, 20'h0};
        lfsr = 32'h00011D9C;
        for (k = 0; k < 6; k++) tp[k] = TAP_RESET;
        repeat (10) @(posedge clock);
        srst <= 1'b0;
        for (i = 0; i < 16; i++)
            rd(4'(i), i < 7 ? {7'h0, SET_RESET} : 16'h0);
        for (i = 0; i < 7; i++) begin
            lfsr = nxt(lfsr);
            wr(4'(i), lfsr[15:0]);
            rd(4'(i), {7'h0, lfsr[8:0]});
        end
        wr(4'hA, 16'hFFFF);
        rd(4'hA, 16'h0);
        wr(4'h2, 16'h0006);
        wr(ADDR_IN_SET, 16'h0001);
        meas(p1);
        chk(16'(p1), 16'(BYP_PER));
        for (i = 0; i < 6; i++) begin
            lfsr = nxt(lfsr);
            s = (i < 3) ? cor[i] : lfsr[8:0];
            wr(ADDR_IN_SET, {7'h0, s});
            meas(p);
            chk(16'(p), 16'(per(s, BYP_PER)));
        end
        for (i = 0; i < 12; i++) begin
            lfsr = nxt(lfsr);
            sl = (i < 7) ? 3'(i) : (lfsr[2:0] == 3'h7 ? 3'h0 : lfsr[2:0]);
            d = lfsr[3];
            for (k = 0; k < 6; k++)
                if ((sl == SEL_ALL && k < 5) || (sl == SEL_FB && k == 5)
                    || sl == 3'(k + 2)) tp[k] = mv(tp[k], d);
            fab.step(sl, d, int'(lfsr[5:4]) + 1);
            repeat (6) @(posedge clock);
            rd(ADDR_TAPS, {1'b0, tp[5], tp[3], tp[2], tp[1], tp[0]});
            rd(4'h9, {13'h0, tp[4]});
            rd(ADDR_STEPS, 16'(i + 1));
        end
        results();
    end
endmodule
`default_nettype wire
